//--- inc/vds_pkg.sv
// constants, register map and field layout of the decoder status bank
// How it works
// RL1 - write-only autolock threshold, default 400, zero disables
// RL2 - control bit 3 forces vertical, 9 flywheel
// RL3 - force set, flywheel clear gives vertical free-run
// RL4 - status bits 0-2: vlock, hlock, no signal
// RL5 - status bits 3-6: killer active and disabled
// RL6 - bits 7-9 interlace, no vsync, spurious; 11:10 zero
// RL7 - lines per field: 312 or 262
// RL8 - field counter increments every video field
// RL9 - measured sync amplitude readable, nominal 768
// RL10 - version: revision 7:0, release 11:8
// RL11 - copy-guard status: bit0 gain pulses, bit1 pseudo sync
// RL12 - window first/last lines, defaults 6 and 15
// RL13 - lock command: write 100/0, read 4095/0
// RL14 - detection only inside window lines, inclusive
// RL15 - field counter wraps; write loads value
package vds_pkg;
	// bus geometry
	localparam int ADDR_W = 12;
	localparam int DATA_W = 32;
	localparam int REG_W = 12;
	localparam int IDX_W = 10;
	localparam int IDX_LSB = 2;
	// register indices, byte address is four times the index
	localparam logic [IDX_W-1:0] IDX_GEN_CTRL = 10'h012;
	localparam logic [IDX_W-1:0] IDX_RECOG_STAT = 10'h013;
	localparam logic [IDX_W-1:0] IDX_FIELD_CNT = 10'h015;
	localparam logic [IDX_W-1:0] IDX_BURST_AMP = 10'h036;
	localparam logic [IDX_W-1:0] IDX_SYNC_AMP = 10'h074;
	localparam logic [IDX_W-1:0] IDX_AUTOLOCK = 10'h0b5;
	localparam logic [IDX_W-1:0] IDX_LINES_PF = 10'h0cb;
	localparam logic [IDX_W-1:0] IDX_FW_VER = 10'h0f0;
	localparam logic [IDX_W-1:0] IDX_LOCK_CMD = 10'h0f7;
	localparam logic [IDX_W-1:0] IDX_CG_STAT = 10'h170;
	localparam logic [IDX_W-1:0] IDX_CG_FIRST = 10'h171;
	localparam logic [IDX_W-1:0] IDX_CG_LAST = 10'h172;
	localparam logic [IDX_W-1:0] IDX_IRQ_STAT = 10'h180;
	localparam logic [IDX_W-1:0] IDX_IRQ_CLR = 10'h181;
	localparam logic [IDX_W-1:0] IDX_IRQ_EN = 10'h182;
	// reset values
	localparam logic [REG_W-1:0] RST_GEN_CTRL = 12'h000;
	localparam logic [REG_W-1:0] RST_AUTOLOCK = 12'h190;
	localparam logic [REG_W-1:0] RST_CG_FIRST = 12'h006;
	localparam logic [REG_W-1:0] RST_CG_LAST = 12'h00f;
	localparam logic [REG_W-1:0] RST_ZERO = 12'h000;
	// control field positions
	localparam int GC_VFORCE = 3;
	localparam int GC_FLYWHEEL_DIS = 9;
	// lines per field
	localparam logic [REG_W-1:0] LPF_625 = 12'h138;
	localparam logic [REG_W-1:0] LPF_525 = 12'h106;
	// line lock command and answer codes
	localparam logic [REG_W-1:0] LOCK_CMD_ON = 12'h064;
	localparam logic [REG_W-1:0] LOCK_CMD_OFF = 12'h000;
	localparam logic [REG_W-1:0] LOCK_RD_LOCKED = 12'hfff;
	localparam logic [REG_W-1:0] LOCK_RD_UNLOCKED = 12'h000;
	// version fields, arbitrary values
	localparam logic [7:0] FW_REVISION = 8'h01;
	localparam logic [3:0] FW_RELEASE = 4'h1;
	// interrupt event bits
	localparam int IRQ_N = 4;
	localparam int EV_FIELD = 0;
	localparam int EV_VLOCK_CHG = 1;
	localparam int EV_CG_DETECT = 2;
	localparam int EV_NO_SIGNAL = 3;
	// bus responses
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

//--- rtl/vds_status_regs.sv
// decoder status and control register bank behind an axi4-lite slave
`timescale 1ns/10ps
module vds_status_regs (
	input wire logic aclk,
	input wire logic aresetn,
	// axi4-lite slave
	input wire logic [vds_pkg::ADDR_W-1:0] s_axi_awaddr,
	input wire logic [2:0] s_axi_awprot,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [vds_pkg::DATA_W-1:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [vds_pkg::ADDR_W-1:0] s_axi_araddr,
	input wire logic [2:0] s_axi_arprot,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [vds_pkg::DATA_W-1:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	// decoder core status, same clock
	input wire logic vert_locked,
	input wire logic horiz_locked,
	input wire logic no_signal,
	input wire logic amp_killer_active,
	input wire logic amp_killer_disabled,
	input wire logic ident_killer_active,
	input wire logic ident_killer_disabled,
	input wire logic interlace_seen,
	input wire logic no_vsync,
	input wire logic spurious_vsync,
	input wire logic std_525_lines,
	input wire logic field_strobe,
	input wire logic line_strobe,
	input wire logic [vds_pkg::REG_W-1:0] sync_amplitude,
	input wire logic [vds_pkg::REG_W-1:0] burst_amplitude,
	input wire logic xtal_locked,
	input wire logic gain_pulse_seen,
	input wire logic pseudo_sync_seen,
	// controls to the decoder core
	output logic [vds_pkg::REG_W-1:0] autolock_threshold,
	output logic autolock_enable,
	output logic xtal_lock_enable,
	output logic vert_std_force,
	output logic flywheel_il_disable,
	output logic vert_free_run,
	output logic irq
);
	import vds_pkg::*;

	// write channel state
	logic aw_have_q;  // address taken, write pending
	logic w_have_q;  // data taken, write pending
	logic [IDX_W-1:0] widx_q;  // held write index
	logic [DATA_W-1:0] wdata_q;  // held write data
	logic [3:0] wstrb_q;  // held byte enables
	logic awready_q;
	logic wready_q;
	logic bvalid_q;
	logic [1:0] bresp_q;
	// read channel state
	logic arready_q;
	logic rvalid_q;
	logic [DATA_W-1:0] rdata_q;
	logic [1:0] rresp_q;
	// software registers
	logic [REG_W-1:0] gen_ctrl_q;
	logic [REG_W-1:0] autolock_q;
	logic [REG_W-1:0] lock_cmd_q;
	logic [REG_W-1:0] field_cnt_q;
	logic [REG_W-1:0] cg_first_q;
	logic [REG_W-1:0] cg_last_q;
	// captured core state
	logic [REG_W-1:0] recog_q;
	logic [REG_W-1:0] sync_amp_q;
	logic [REG_W-1:0] burst_amp_q;
	logic lock_state_q;
	logic std_525_q;
	// copy-guard window tracking
	logic [REG_W-1:0] line_q;  // current line in field
	logic [1:0] cg_acc_q;  // detections this field
	logic [1:0] cg_stat_q;  // last field's result
	// interrupts
	logic [IRQ_N-1:0] irq_stat_q;
	logic [IRQ_N-1:0] irq_en_q;
	logic irq_q;
	logic vlock_prev_q;
	logic nosig_prev_q;
	// control outputs
	logic xlock_en_q;
	logic autolock_en_q;
	logic vfrun_q;

	// combinational helpers
	logic do_write;  // both halves of a write present
	logic wr_hit;  // write index decodes
	logic [REG_W-1:0] wval;  // write value after byte enables
	logic rd_hit;
	logic [REG_W-1:0] rval;
	logic [IDX_W-1:0] ridx;
	logic in_window;
	logic [IRQ_N-1:0] irq_ev;
	logic [IRQ_N-1:0] irq_stat_d;

	// write happens once address and data are both held
	assign do_write = aw_have_q && w_have_q && !bvalid_q;
	assign ridx = s_axi_araddr[IDX_LSB +: IDX_W];

	// merge byte lanes into the 12-bit value
	function automatic logic [REG_W-1:0] lane_merge(
		input logic [REG_W-1:0] old,
		input logic [DATA_W-1:0] d,
		input logic [3:0] be
	);
		logic [REG_W-1:0] r;
		r = old;
		if (be[0]) begin
			r[7:0] = d[7:0];
		end
		if (be[1]) begin
			r[REG_W-1:8] = d[REG_W-1:8];
		end
		return r;
	endfunction

	// address decode for writes
	always_comb begin
		wr_hit = 1'b1;
		wval = RST_ZERO;
		case (widx_q)
			IDX_GEN_CTRL: wval = lane_merge(gen_ctrl_q, wdata_q, wstrb_q);
			IDX_AUTOLOCK: wval = lane_merge(autolock_q, wdata_q, wstrb_q);
			IDX_LOCK_CMD: wval = lane_merge(lock_cmd_q, wdata_q, wstrb_q);
			IDX_FIELD_CNT: wval = lane_merge(field_cnt_q, wdata_q, wstrb_q);
			IDX_CG_FIRST: wval = lane_merge(cg_first_q, wdata_q, wstrb_q);
			IDX_CG_LAST: wval = lane_merge(cg_last_q, wdata_q, wstrb_q);
			IDX_IRQ_CLR,
			IDX_IRQ_EN: wval = lane_merge(RST_ZERO, wdata_q, wstrb_q);
			// read-only registers accept and drop the write
			IDX_RECOG_STAT, IDX_BURST_AMP, IDX_SYNC_AMP, IDX_LINES_PF,
			IDX_FW_VER, IDX_CG_STAT, IDX_IRQ_STAT: wval = RST_ZERO;
			default: wr_hit = 1'b0;
		endcase
	end

	// write address channel
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			awready_q <= 1'b1;
			aw_have_q <= 1'b0;
			widx_q <= '0;
		end else if (s_axi_awvalid && awready_q) begin
			awready_q <= 1'b0;
			aw_have_q <= 1'b1;
			widx_q <= s_axi_awaddr[IDX_LSB +: IDX_W];
		end else if (do_write) begin
			aw_have_q <= 1'b0;
		end else if (s_axi_bready && bvalid_q) begin
			awready_q <= 1'b1;
		end
	end

	// write data channel
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			wready_q <= 1'b1;
			w_have_q <= 1'b0;
			wdata_q <= '0;
			wstrb_q <= '0;
		end else if (s_axi_wvalid && wready_q) begin
			wready_q <= 1'b0;
			w_have_q <= 1'b1;
			wdata_q <= s_axi_wdata;
			wstrb_q <= s_axi_wstrb;
		end else if (do_write) begin
			w_have_q <= 1'b0;
		end else if (s_axi_bready && bvalid_q) begin
			wready_q <= 1'b1;
		end
	end

	// write response, error on unmapped index
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			bvalid_q <= 1'b0;
			bresp_q <= RESP_OKAY;
		end else if (do_write) begin
			bvalid_q <= 1'b1;
			bresp_q <= wr_hit ? RESP_OKAY : RESP_SLVERR;
		end else if (s_axi_bready) begin
			bvalid_q <= 1'b0;
		end
	end

	// general control, reserved bits keep what software wrote
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			gen_ctrl_q <= RST_GEN_CTRL;
		end else if (do_write && widx_q == IDX_GEN_CTRL) begin
			gen_ctrl_q <= wval;  // RL2
		end
	end

	// vertical force, flywheel disable and free-run decode
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			vfrun_q <= 1'b0;
		end else begin
			vfrun_q <= gen_ctrl_q[GC_VFORCE] &&
				!gen_ctrl_q[GC_FLYWHEEL_DIS];  // RL3
		end
	end

	// autolock threshold, zero turns the feature off
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			autolock_q <= RST_AUTOLOCK;
			autolock_en_q <= 1'b1;
		end else if (do_write && widx_q == IDX_AUTOLOCK) begin
			autolock_q <= wval;  // RL1
			autolock_en_q <= (wval != RST_ZERO);  // RL1
		end
	end

	// line lock command, only the two codes act
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			lock_cmd_q <= RST_ZERO;
			xlock_en_q <= 1'b0;
		end else if (do_write && widx_q == IDX_LOCK_CMD) begin
			lock_cmd_q <= wval;
			if (wval == LOCK_CMD_ON) begin
				xlock_en_q <= 1'b1;  // RL13
			end else if (wval == LOCK_CMD_OFF) begin
				xlock_en_q <= 1'b0;  // RL13
			end
		end
	end

	// field counter, software load beats the field step
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			field_cnt_q <= RST_ZERO;
		end else if (do_write && widx_q == IDX_FIELD_CNT) begin
			field_cnt_q <= wval;  // RL15
		end else if (field_strobe) begin
			field_cnt_q <= field_cnt_q + 1'b1;  // RL8 RL15
		end
	end

	// copy-guard window bounds
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			cg_first_q <= RST_CG_FIRST;
			cg_last_q <= RST_CG_LAST;
		end else if (do_write && widx_q == IDX_CG_FIRST) begin
			cg_first_q <= wval;  // RL12
		end else if (do_write && widx_q == IDX_CG_LAST) begin
			cg_last_q <= wval;  // RL12
		end
	end

	// line number within the field, first line is one
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			line_q <= RST_ZERO;
		end else if (field_strobe) begin
			line_q <= 12'h001;
		end else if (line_strobe && line_q != '1) begin
			line_q <= line_q + 1'b1;
		end
	end

	assign in_window = (line_q >= cg_first_q) && (line_q <= cg_last_q);

	// collect detections in window, publish at field end
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			cg_acc_q <= 2'h0;
			cg_stat_q <= 2'h0;
		end else if (field_strobe) begin
			cg_stat_q <= cg_acc_q;  // RL11
			cg_acc_q <= 2'h0;
		end else if (in_window) begin
			cg_acc_q <= cg_acc_q |
				{pseudo_sync_seen, gain_pulse_seen};  // RL14
		end
	end

	// capture of core status for reads
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			recog_q <= RST_ZERO;
			sync_amp_q <= RST_ZERO;
			burst_amp_q <= RST_ZERO;
			lock_state_q <= 1'b0;
			std_525_q <= 1'b0;
		end else begin
			recog_q <= {2'b00,  // RL6
				spurious_vsync, no_vsync, interlace_seen,  // RL6
				ident_killer_disabled, ident_killer_active,  // RL5
				amp_killer_disabled, amp_killer_active,  // RL5
				no_signal, horiz_locked, vert_locked};  // RL4
			sync_amp_q <= sync_amplitude;  // RL9
			burst_amp_q <= burst_amplitude;
			lock_state_q <= xtal_locked;
			std_525_q <= std_525_lines;
		end
	end

	// events that raise interrupt status
	always_comb begin
		irq_ev = '0;
		irq_ev[EV_FIELD] = field_strobe;
		irq_ev[EV_VLOCK_CHG] = vert_locked != vlock_prev_q;
		irq_ev[EV_CG_DETECT] = field_strobe && (cg_acc_q != 2'h0);
		irq_ev[EV_NO_SIGNAL] = no_signal && !nosig_prev_q;
		irq_stat_d = irq_stat_q;
		if (do_write && widx_q == IDX_IRQ_CLR) begin
			irq_stat_d = irq_stat_d & ~wval[IRQ_N-1:0];
		end
		irq_stat_d = irq_stat_d | irq_ev;  // new event beats clear
	end

	// interrupt status, enable and output
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			irq_stat_q <= '0;
			irq_en_q <= '0;
			irq_q <= 1'b0;
			vlock_prev_q <= 1'b0;
			nosig_prev_q <= 1'b0;
		end else begin
			irq_stat_q <= irq_stat_d;
			vlock_prev_q <= vert_locked;
			nosig_prev_q <= no_signal;
			irq_q <= |(irq_stat_d & irq_en_q);
			if (do_write && widx_q == IDX_IRQ_EN) begin
				irq_en_q <= wval[IRQ_N-1:0];
			end
		end
	end

	// read mux, write-only threshold reads zero
	always_comb begin
		rd_hit = 1'b1;
		rval = RST_ZERO;
		case (ridx)
			IDX_GEN_CTRL: rval = gen_ctrl_q;
			IDX_RECOG_STAT: rval = recog_q;  // RL4 RL5 RL6
			IDX_FIELD_CNT: rval = field_cnt_q;  // RL8
			IDX_BURST_AMP: rval = burst_amp_q;
			IDX_SYNC_AMP: rval = sync_amp_q;  // RL9
			IDX_AUTOLOCK: rval = RST_ZERO;  // RL1
			IDX_LINES_PF: rval = std_525_q ? LPF_525 : LPF_625;  // RL7
			IDX_FW_VER: rval = {FW_RELEASE, FW_REVISION};  // RL10
			IDX_LOCK_CMD: rval = lock_state_q ?
				LOCK_RD_LOCKED : LOCK_RD_UNLOCKED;  // RL13
			IDX_CG_STAT: rval = {10'h000, cg_stat_q};  // RL11
			IDX_CG_FIRST: rval = cg_first_q;
			IDX_CG_LAST: rval = cg_last_q;
			IDX_IRQ_STAT: rval = {8'h00, irq_stat_q};
			IDX_IRQ_EN: rval = {8'h00, irq_en_q};
			IDX_IRQ_CLR: rval = RST_ZERO;
			default: rd_hit = 1'b0;
		endcase
	end

	// read channel, answer one cycle after address taken
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			arready_q <= 1'b1;
			rvalid_q <= 1'b0;
			rdata_q <= '0;
			rresp_q <= RESP_OKAY;
		end else if (s_axi_arvalid && arready_q) begin
			arready_q <= 1'b0;
			rvalid_q <= 1'b1;
			rdata_q <= {20'h0_0000, rval};
			rresp_q <= rd_hit ? RESP_OKAY : RESP_SLVERR;
		end else if (rvalid_q && s_axi_rready) begin
			rvalid_q <= 1'b0;
			arready_q <= 1'b1;
		end
	end

	// outputs straight from flops
	assign s_axi_awready = awready_q;
	assign s_axi_wready = wready_q;
	assign s_axi_bvalid = bvalid_q;
	assign s_axi_bresp = bresp_q;
	assign s_axi_arready = arready_q;
	assign s_axi_rvalid = rvalid_q;
	assign s_axi_rdata = rdata_q;
	assign s_axi_rresp = rresp_q;
	assign autolock_threshold = autolock_q;
	assign autolock_enable = autolock_en_q;
	assign xtal_lock_enable = xlock_en_q;
	assign vert_std_force = gen_ctrl_q[GC_VFORCE];  // RL2
	assign flywheel_il_disable = gen_ctrl_q[GC_FLYWHEEL_DIS];  // RL2
	assign vert_free_run = vfrun_q;
	assign irq = irq_q;
endmodule // vds_status_regs

//--- dv/vds_status_regs_chk.sv
// port assertions for the decoder status register bank
`timescale 1ns/10ps
module vds_status_regs_chk (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [11:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	input wire logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic s_axi_wvalid,
	input wire logic s_axi_wready,
	input wire logic [11:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic std_525_lines,
	input wire logic [11:0] sync_amplitude,
	input wire logic xtal_locked,
	input wire logic [11:0] autolock_threshold,
	input wire logic autolock_enable,
	input wire logic vert_std_force,
	input wire logic flywheel_il_disable,
	input wire logic vert_free_run
);
	import vds_pkg::*;
	logic ar_hs; // read address taken
	logic w_hs; // write address and data taken together
	logic [9:0] ar_idx; // register index of a read
	assign ar_hs = s_axi_arvalid && s_axi_arready;
	assign w_hs = s_axi_awvalid && s_axi_awready
		&& s_axi_wvalid && s_axi_wready;
	assign ar_idx = s_axi_araddr[11:2];
	default clocking cb @(posedge aclk);
	endclocking
	default disable iff (!aresetn);
	a_thresh_reset: assert property (
		$rose(aresetn) |-> autolock_threshold == RST_AUTOLOCK)
		else $error("threshold not at default after reset");
	a_alock_follow: assert property (
		autolock_enable == (autolock_threshold != 12'h000))
		else $error("autolock enable disagrees with threshold");
	a_free_run: assert property (
		$stable(vert_std_force) && $stable(flywheel_il_disable)
		|-> vert_free_run == (vert_std_force && !flywheel_il_disable))
		else $error("free run does not follow control bits");
	a_ctrl_write: assert property (
		w_hs && s_axi_awaddr[11:2] == IDX_GEN_CTRL |-> ##2
		vert_std_force == $past(s_axi_wdata[3], 2)
		&& flywheel_il_disable == $past(s_axi_wdata[9], 2))
		else $error("control write not applied");
	a_lock_read: assert property (
		ar_hs && ar_idx == IDX_LOCK_CMD && xtal_locked && $past(xtal_locked)
		|=> s_axi_rdata[11:0] == LOCK_RD_LOCKED)
		else $error("lock status read wrong");
	a_status_resv: assert property (
		ar_hs && ar_idx == IDX_RECOG_STAT |=> s_axi_rdata[31:10] == '0)
		else $error("reserved status bits not zero");
	a_lines_read: assert property (
		ar_hs && ar_idx == IDX_LINES_PF && $stable(std_525_lines)
		|=> s_axi_rdata[11:0] == ($past(std_525_lines) ? LPF_525 : LPF_625))
		else $error("lines per field read wrong");
	a_sync_read: assert property (
		ar_hs && ar_idx == IDX_SYNC_AMP && $stable(sync_amplitude)
		|=> s_axi_rdata[11:0] == $past(sync_amplitude))
		else $error("sync amplitude read wrong");
	a_version_read: assert property (
		ar_hs && ar_idx == IDX_FW_VER
		|=> s_axi_rdata[11:0] == {FW_RELEASE, FW_REVISION})
		else $error("version read wrong");
endmodule // vds_status_regs_chk

bind vds_status_regs vds_status_regs_chk u_chk (.aclk(aclk),
	.aresetn(aresetn), .s_axi_awaddr(s_axi_awaddr),
	.s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
	.s_axi_wdata(s_axi_wdata), .s_axi_wvalid(s_axi_wvalid),
	.s_axi_wready(s_axi_wready), .s_axi_araddr(s_axi_araddr),
	.s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
	.s_axi_rdata(s_axi_rdata), .std_525_lines(std_525_lines),
	.sync_amplitude(sync_amplitude), .xtal_locked(xtal_locked),
	.autolock_threshold(autolock_threshold),
	.autolock_enable(autolock_enable), .vert_std_force(vert_std_force),
	.flywheel_il_disable(flywheel_il_disable),
	.vert_free_run(vert_free_run));

//--- dv/vds_status_regs_tb.sv
// register-level testbench for the decoder status bank
`timescale 1ns/10ps
module vds_status_regs_tb;
	import vds_pkg::*;
	logic aclk, aresetn, awv, wv, bre, arv, rre, fs, ls, std, xl, gp, ps;
	logic awr, wr_rdy, bv, arr, rv, ale, xle, vsf, fid, vfr, irq;
	logic [11:0] awa, ara, sa, ba, thr;
	logic [31:0] wd, rdata;
	logic [9:0] st; // core status levels, bits 0..9
	logic [1:0] bresp, rresp;
	logic [3:0] ws; // write byte enables
	int checks, mismatches, cycles;
	vds_status_regs u_vds_status_regs (.aclk(aclk), .aresetn(aresetn),
		.s_axi_awaddr(awa), .s_axi_awprot(3'h0), .s_axi_awvalid(awv),
		.s_axi_awready(awr), .s_axi_wdata(wd), .s_axi_wstrb(ws),
		.s_axi_wvalid(wv), .s_axi_wready(wr_rdy), .s_axi_bresp(bresp),
		.s_axi_bvalid(bv), .s_axi_bready(bre), .s_axi_araddr(ara),
		.s_axi_arprot(3'h0), .s_axi_arvalid(arv), .s_axi_arready(arr),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rv),
		.s_axi_rready(rre), .vert_locked(st[0]), .horiz_locked(st[1]),
		.no_signal(st[2]), .amp_killer_active(st[3]),
		.amp_killer_disabled(st[4]), .ident_killer_active(st[5]),
		.ident_killer_disabled(st[6]), .interlace_seen(st[7]),
		.no_vsync(st[8]), .spurious_vsync(st[9]), .std_525_lines(std),
		.field_strobe(fs), .line_strobe(ls), .sync_amplitude(sa),
		.burst_amplitude(ba), .xtal_locked(xl), .gain_pulse_seen(gp),
		.pseudo_sync_seen(ps), .autolock_threshold(thr),
		.autolock_enable(ale), .xtal_lock_enable(xle),
		.vert_std_force(vsf), .flywheel_il_disable(fid),
		.vert_free_run(vfr), .irq(irq));
	// 100 MHz clock
	initial begin
		aclk = 1'b0;
		forever #5 aclk = ~aclk;
	end
	// compare and count
	task chk(input logic [31:0] seen, input logic [31:0] exp);
		checks++;
		if (seen !== exp) begin
			mismatches++;
			$display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task cyc(input int n);
		repeat (n) @(posedge aclk);
	endtask
	// one write, address and data offered together
	task wr(input logic [9:0] idx, input logic [11:0] d, input logic [1:0] er);
		@(posedge aclk);
		awa <= {idx, 2'b00};
		wd <= {20'h0_0000, d};
		awv <= 1'b1;
		wv <= 1'b1;
		bre <= 1'b1;
		do begin
			@(posedge aclk);
			if (awr) awv <= 1'b0;
			if (wr_rdy) wv <= 1'b0;
		end while (!bv);
		bre <= 1'b0;
		chk(bresp, er);
	endtask
	// one read, data and response compared
	task rd(input logic [9:0] idx, input logic [31:0] exp, input logic [1:0] er);
		@(posedge aclk);
		ara <= {idx, 2'b00};
		arv <= 1'b1;
		rre <= 1'b1;
		do begin
			@(posedge aclk);
			if (arr) arv <= 1'b0;
		end while (!rv);
		rre <= 1'b0;
		chk(rdata, exp);
		chk(rresp, er);
	endtask
	// one-cycle field pulse
	task fld;
		@(posedge aclk);
		fs <= 1'b1;
		@(posedge aclk);
		fs <= 1'b0;
	endtask
	// one field with pulses m on line l, then read copy status
	task cgf(input int l, input logic [1:0] m, input logic [11:0] exp);
		fld;
		for (int n = 1; n < 19; n++) begin
			@(posedge aclk);
			gp <= m[0] && n == l;
			ps <= m[1] && n == l;
			cyc(2);
			gp <= 1'b0;
			ps <= 1'b0;
			ls <= 1'b1;
			@(posedge aclk);
			ls <= 1'b0;
		end
		fld;
		cyc(3);
		rd(IDX_CG_STAT, exp, RESP_OKAY);
	endtask
	task done(input string s);
		$display("test %s finished", s);
	endtask
	task conclude;
		$display("checks=%0d mismatches=%0d", checks, mismatches);
		if (mismatches == 0 && checks > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	// hang guard
	always @(posedge aclk) begin
		cycles++;
		if (cycles == 20000) begin
			mismatches++;
			conclude;
		end
	end
	initial begin
		{aresetn, awv, wv, bre, arv, rre, fs, ls, std, xl, gp, ps} = '0;
		{awa, ara, sa, ba, wd, st} = '0;
		ws = 4'hf;
		cyc(16);
		aresetn <= 1'b1;
		chk(thr, RST_AUTOLOCK);
		rd(IDX_AUTOLOCK, 0, RESP_OKAY);
		rd(IDX_GEN_CTRL, RST_GEN_CTRL, RESP_OKAY);
		rd(IDX_CG_FIRST, RST_CG_FIRST, RESP_OKAY);
		rd(IDX_CG_LAST, RST_CG_LAST, RESP_OKAY);
		done("reset");
		wr(IDX_AUTOLOCK, 12'h000, RESP_OKAY);
		cyc(1);
		chk(ale, 1'b0);
		wr(IDX_AUTOLOCK, 12'h001, RESP_OKAY);
		cyc(1);
		chk({ale, thr}, 13'h1_001);
		wr(IDX_GEN_CTRL, 12'h008, RESP_OKAY);
		cyc(2);
		chk({vsf, fid, vfr}, 3'h5);
		wr(IDX_GEN_CTRL, 12'h208, RESP_OKAY);
		cyc(2);
		chk({vsf, fid, vfr}, 3'h6);
		rd(IDX_GEN_CTRL, 12'h208, RESP_OKAY);
		done("control");
		for (int i = 0; i < 10; i++) begin
			st <= 10'h001 << i;
			cyc(2);
			rd(IDX_RECOG_STAT, 32'h0000_0001 << i, RESP_OKAY);
		end
		std <= 1'b1;
		cyc(2);
		rd(IDX_LINES_PF, LPF_525, RESP_OKAY);
		wr(IDX_LINES_PF, 12'h000, RESP_OKAY);
		std <= 1'b0;
		cyc(2);
		rd(IDX_LINES_PF, LPF_625, RESP_OKAY);
		sa <= 12'h300;
		ba <= 12'h0a5;
		cyc(2);
		rd(IDX_SYNC_AMP, 12'h300, RESP_OKAY);
		rd(IDX_BURST_AMP, 12'h0a5, RESP_OKAY);
		rd(IDX_FW_VER, {FW_RELEASE, FW_REVISION}, RESP_OKAY);
		done("status");
		wr(IDX_FIELD_CNT, 12'hffe, RESP_OKAY);
		repeat (3) fld;
		rd(IDX_FIELD_CNT, 12'h001, RESP_OKAY);
		done("field count");
		wr(IDX_LOCK_CMD, LOCK_CMD_ON, RESP_OKAY);
		xl <= 1'b1;
		cyc(2);
		chk(xle, 1'b1);
		wr(IDX_LOCK_CMD, 12'h005, RESP_OKAY);
		cyc(1);
		chk(xle, 1'b1);
		rd(IDX_LOCK_CMD, LOCK_RD_LOCKED, RESP_OKAY);
		xl <= 1'b0;
		cyc(2);
		rd(IDX_LOCK_CMD, LOCK_RD_UNLOCKED, RESP_OKAY);
		wr(IDX_LOCK_CMD, LOCK_CMD_OFF, RESP_OKAY);
		cyc(1);
		chk(xle, 1'b0);
		done("line lock");
		cgf(5, 2'h3, 12'h000);
		cgf(6, 2'h1, 12'h001);
		cgf(15, 2'h2, 12'h002);
		cgf(16, 2'h3, 12'h000);
		wr(IDX_CG_FIRST, 12'h002, RESP_OKAY);
		wr(IDX_CG_LAST, 12'h003, RESP_OKAY);
		cgf(2, 2'h3, 12'h003);
		cgf(6, 2'h3, 12'h000);
		ws <= 4'h2;
		wr(IDX_CG_LAST, 12'ha55, RESP_OKAY);
		ws <= 4'hf;
		rd(IDX_CG_LAST, 12'ha03, RESP_OKAY);
		done("copy guard");
		rd(IDX_IRQ_STAT, 12'h00f, RESP_OKAY);
		wr(IDX_IRQ_EN, 12'h00f, RESP_OKAY);
		cyc(2);
		chk(irq, 1'b1);
		wr(IDX_IRQ_CLR, 12'h00f, RESP_OKAY);
		cyc(2);
		chk(irq, 1'b0);
		wr(IDX_IRQ_EN, 12'h001, RESP_OKAY);
		fld;
		cyc(2);
		chk(irq, 1'b1);
		rd(IDX_IRQ_STAT, 12'h001, RESP_OKAY);
		wr(IDX_IRQ_EN, 12'h000, RESP_OKAY);
		cyc(2);
		chk(irq, 1'b0);
		wr(IDX_IRQ_CLR, 12'h001, RESP_OKAY);
		rd(IDX_IRQ_STAT, 12'h000, RESP_OKAY);
		done("interrupt");
		aresetn <= 1'b0;
		cyc(4);
		aresetn <= 1'b1;
		chk({ale, thr}, {1'b1, RST_AUTOLOCK});
		rd(IDX_CG_LAST, RST_CG_LAST, RESP_OKAY);
		done("reset again");
		wr(10'h1ff, 12'h123, RESP_SLVERR);
		rd(10'h1ff, 0, RESP_SLVERR);
		done("unmapped");
		conclude;
	end
endmodule // vds_status_regs_tb
